// ---- src/stack_addr.sv ----
// stack address forming and wrapping pointer arithmetic
`timescale 1ns/1ps
module stack_addr
  import stack_pkg::*;
(
  input  wire logic [SP_W-1:0]   i_sp,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [ADDR_W-1:0] o_addr_inc,
  output logic      [SP_W-1:0]   o_sp_inc,
  output logic      [SP_W-1:0]   o_sp_dec
);

  // pointer wraps inside its width, so the page never changes
  assign o_sp_inc   = SP_W'(i_sp + 1'b1);
  assign o_sp_dec   = SP_W'(i_sp - 1'b1);
  assign o_addr     = {STACK_PAGE, i_sp};
  assign o_addr_inc = {STACK_PAGE, o_sp_inc};

endmodule

// ---- src/stack_decode.sv ----
// one-byte implied opcode decoder for the stack instructions
`timescale 1ns/1ps
module stack_decode
  import stack_pkg::*;
(
  input  wire logic [7:0]  i_opcode,
  output op_kind_type      o_kind,
  output logic             o_uses_stack
);

  // whole instruction is one byte, no operand fetch follows
  always_comb begin
    unique case (i_opcode)
      OPC_ITER_TO_SP: o_kind = K_ITER_TO_SP;
      OPC_SP_TO_ITER: o_kind = K_SP_TO_ITER;
      OPC_PUSH_ACC:   o_kind = K_PUSH_ACC;
      OPC_PUSH_PSW:   o_kind = K_PUSH_PSW;
      OPC_PULL_ACC:   o_kind = K_PULL_ACC;
      OPC_PULL_PSW:   o_kind = K_PULL_PSW;
      OPC_SW_BREAK:   o_kind = K_SW_BREAK;
      OPC_SUB_CALL:   o_kind = K_SUB_CALL;
      OPC_INT_RETURN: o_kind = K_INT_RETURN;
      OPC_SUB_RETURN: o_kind = K_SUB_RETURN;
      default:        o_kind = K_NONE;
    endcase
  end

  // exactly eight instructions touch the stack
  assign o_uses_stack = (o_kind != K_ITER_TO_SP) && (o_kind != K_SP_TO_ITER)
                        && (o_kind != K_NONE);

endmodule

// ---- src/stack_pkg.sv ----
// shared constants and types for the stack pointer unit
package stack_pkg;

  localparam int SP_W   = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int PADDR_W = 12;

  // stack lives in one fixed page
  localparam logic [7:0] STACK_PAGE = 8'h01;

  // reset values
  localparam logic [7:0] SP_RESET  = 8'hFF;
  localparam logic [7:0] IX_RESET  = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;

  // register byte offsets
  localparam logic [11:0] OFF_CMD    = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_SP     = 12'h008;
  localparam logic [11:0] OFF_IX     = 12'h00C;
  localparam logic [11:0] OFF_ACC    = 12'h010;
  localparam logic [11:0] OFF_PSW    = 12'h014;

  // field positions
  localparam int CMD_INT_BIT    = 8;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_UNSUP_BIT = 1;
  localparam int STAT_USES_BIT  = 2;
  localparam int PSW_N_BIT      = 7;
  localparam int PSW_Z_BIT      = 1;

  // opcode values, arbitrary encoding
  localparam logic [7:0] OPC_ITER_TO_SP = 8'h01;
  localparam logic [7:0] OPC_SP_TO_ITER = 8'h02;
  localparam logic [7:0] OPC_PUSH_ACC   = 8'h03;
  localparam logic [7:0] OPC_PUSH_PSW   = 8'h04;
  localparam logic [7:0] OPC_PULL_ACC   = 8'h05;
  localparam logic [7:0] OPC_PULL_PSW   = 8'h06;
  localparam logic [7:0] OPC_SW_BREAK   = 8'h07;
  localparam logic [7:0] OPC_SUB_CALL   = 8'h08;
  localparam logic [7:0] OPC_INT_RETURN = 8'h09;
  localparam logic [7:0] OPC_SUB_RETURN = 8'h0A;

  typedef enum logic [3:0] {
    K_ITER_TO_SP, K_SP_TO_ITER, K_PUSH_ACC, K_PUSH_PSW, K_PULL_ACC,
    K_PULL_PSW, K_SW_BREAK, K_SUB_CALL, K_INT_RETURN, K_SUB_RETURN, K_NONE
  } op_kind_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } mem_req_type;

endpackage

// ---- src/stack_unit.sv ----
// stack pointer unit with APB register access and stack memory port
`timescale 1ns/1ps
//
// Operation
// - iterator-to-sp copies iterator into sp, flags untouched
// - sp-to-iterator copies sp into iterator, sets N and Z only
// - iterator-to-sp is a one-byte implied opcode
// - sp-to-iterator is a one-byte implied opcode
// - push status word stores it unchanged, only sp moves
// - push status word is a one-byte implied opcode
// - pull status word loads whole status byte, only sp moves
// - pull status word is a one-byte implied opcode
// - every stack address is page 0100 hex plus sp
// - a push writes at current address, then decrements sp
// - a pull increments sp first, then reads at new address
// - interrupt entry pushes the status word automatically
// - exactly eight instructions use the stack
// - push accumulator takes three cycles, write in the third
// - pulls add a discarded read while sp increments
// - pull accumulator sets N and Z, leaves carry and overflow
module stack_unit
  import stack_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [stack_pkg::PADDR_W-1:0] i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  output stack_pkg::mem_req_type         o_mem,
  input  wire logic [stack_pkg::DATA_W-1:0] i_mem_rdata
);
  import stack_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DECODE, ST_PUSH, ST_PULL_DUMMY, ST_PULL_READ
  } state_type;

  state_type         state_r;
  logic [SP_W-1:0]   sp_r;
  logic [7:0]        ix_r;
  logic [7:0]        acc_r;
  logic [7:0]        psw_r;
  logic [7:0]        opcode_r;
  logic              int_entry_r;
  logic              unsup_r;
  op_kind_type       kind;
  logic              uses_stack;
  logic [ADDR_W-1:0] addr_cur;
  logic [ADDR_W-1:0] addr_inc;
  logic [SP_W-1:0]   sp_inc;
  logic [SP_W-1:0]   sp_dec;
  logic              wr_go;
  logic              setup;
  logic              cmd_go;
  logic              push_kind;
  logic              pull_kind;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  stack_decode u_decode (
    .i_opcode     (opcode_r),
    .o_kind       (kind),
    .o_uses_stack (uses_stack)
  );

  stack_addr u_addr (
    .i_sp       (sp_r),
    .o_addr     (addr_cur),
    .o_addr_inc (addr_inc),
    .o_sp_inc   (sp_inc),
    .o_sp_dec   (sp_dec)
  );

  // N from bit 7, Z on zero, all other bits kept
  function automatic logic [7:0] set_nz(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    r            = p;
    r[PSW_N_BIT] = v[7];
    r[PSW_Z_BIT] = (v == 8'h00);
    return r;
  endfunction

  // interrupt entry is handled as a status push
  assign push_kind = int_entry_r || (kind == K_PUSH_ACC) || (kind == K_PUSH_PSW);
  assign pull_kind = !int_entry_r && ((kind == K_PULL_ACC) || (kind == K_PULL_PSW));

  //////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  assign setup  = i_psel && !i_penable;
  assign wr_go  = i_psel && i_penable && i_pwrite && o_pready;
  // commands while busy are dropped; software polls the busy bit
  assign cmd_go = wr_go && (i_paddr == OFF_CMD) && (state_r == ST_IDLE);

  // ready rises after reset and then stays high
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= 1'b1;
    end
  end

  // read data and error prepared in the setup cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      unique case (i_paddr)
        OFF_CMD:    o_prdata <= {23'h00_0000, int_entry_r, opcode_r};
        OFF_STATUS: o_prdata <= {29'h0000_0000, uses_stack, unsup_r, state_r != ST_IDLE};
        OFF_SP:     o_prdata <= {24'h00_0000, sp_r};
        OFF_IX:     o_prdata <= {24'h00_0000, ix_r};
        OFF_ACC:    o_prdata <= {24'h00_0000, acc_r};
        OFF_PSW:    o_prdata <= {24'h00_0000, psw_r};
        default:    o_pslverr <= 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command capture and sequencer

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      opcode_r    <= 8'h00;
      int_entry_r <= 1'b0;
    end else if (cmd_go) begin
      opcode_r    <= i_pwdata[7:0];
      int_entry_r <= i_pwdata[CMD_INT_BIT];
    end
  end

  // decode cycle, then at most two memory cycles
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE:       if (cmd_go) state_r <= ST_DECODE;
        ST_DECODE: begin
          if (push_kind) begin
            state_r <= ST_PUSH;
          end else if (pull_kind) begin
            state_r <= ST_PULL_DUMMY;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_PUSH:       state_r <= ST_IDLE;
        ST_PULL_DUMMY: state_r <= ST_PULL_READ;
        ST_PULL_READ:  state_r <= ST_IDLE;
      endcase
    end
  end

  // memory request registered one cycle ahead of its state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mem <= '0;
    end else begin
      o_mem.we <= 1'b0;
      o_mem.re <= 1'b0;
      if (state_r == ST_DECODE && push_kind) begin
        o_mem.addr  <= addr_cur;
        o_mem.wdata <= (kind == K_PUSH_ACC && !int_entry_r) ? acc_r : psw_r;
        o_mem.we    <= 1'b1;
      end else if (state_r == ST_DECODE && pull_kind) begin
        o_mem.addr <= addr_cur;   // discarded read at old pointer
        o_mem.re   <= 1'b1;
      end else if (state_r == ST_PULL_DUMMY) begin
        o_mem.addr <= addr_inc;
        o_mem.re   <= 1'b1;
      end
    end
  end

  // stack pointer: only the transfer or push/pull moves it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sp_r <= SP_RESET;
    end else if (state_r == ST_DECODE && !int_entry_r && kind == K_ITER_TO_SP) begin
      sp_r <= ix_r;
    end else if (state_r == ST_PUSH) begin
      sp_r <= sp_dec;
    end else if (state_r == ST_PULL_DUMMY) begin
      sp_r <= sp_inc;
    end
  end

  // iterator register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ix_r <= IX_RESET;
    end else if (state_r == ST_DECODE && !int_entry_r && kind == K_SP_TO_ITER) begin
      ix_r <= sp_r;
    end else if (wr_go && i_paddr == OFF_IX && state_r == ST_IDLE) begin
      ix_r <= i_pwdata[7:0];
    end
  end

  // accumulator
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      acc_r <= ACC_RESET;
    end else if (state_r == ST_PULL_READ && kind == K_PULL_ACC) begin
      acc_r <= i_mem_rdata;
    end else if (wr_go && i_paddr == OFF_ACC && state_r == ST_IDLE) begin
      acc_r <= i_pwdata[7:0];
    end
  end

  // status word: N/Z updates, whole load on pull
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      psw_r <= PSW_RESET;
    end else if (state_r == ST_DECODE && !int_entry_r && kind == K_SP_TO_ITER) begin
      psw_r <= set_nz(psw_r, sp_r);
    end else if (state_r == ST_PULL_READ && kind == K_PULL_ACC) begin
      psw_r <= set_nz(psw_r, i_mem_rdata);
    end else if (state_r == ST_PULL_READ && kind == K_PULL_PSW) begin
      psw_r <= i_mem_rdata;
    end else if (wr_go && i_paddr == OFF_PSW && state_r == ST_IDLE) begin
      psw_r <= i_pwdata[7:0];
    end
  end

  // unknown opcode flag; a new event wins over the clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      unsup_r <= 1'b0;
    end else if (state_r == ST_DECODE && !int_entry_r && kind == K_NONE) begin
      unsup_r <= 1'b1;
    end else if (wr_go && i_paddr == OFF_STATUS && i_pwdata[STAT_UNSUP_BIT]) begin
      unsup_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence push_steps;
    state_r == ST_DECODE ##1 state_r == ST_PUSH ##1 state_r == ST_IDLE;
  endsequence

  sequence pull_steps;
    state_r == ST_DECODE ##1 state_r == ST_PULL_DUMMY ##1 state_r == ST_PULL_READ;
  endsequence

  chk_push_len: assert property (@(posedge i_clk) disable iff (i_reset)
    cmd_go && i_pwdata[7:0] == OPC_PUSH_ACC |=> push_steps)
    else $error("push did not take decode then one write cycle");

  chk_pull_len: assert property (@(posedge i_clk) disable iff (i_reset)
    cmd_go && i_pwdata[7:0] == OPC_PULL_PSW && !i_pwdata[CMD_INT_BIT] |=> pull_steps)
    else $error("pull did not take dummy then read cycle");

  chk_push_addr: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_PUSH |-> o_mem.we && o_mem.addr == {STACK_PAGE, sp_r} ##1 sp_r == $past(sp_r) - 8'h01)
    else $error("push address or decrement wrong");

  chk_pull_addr: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_PULL_DUMMY |=> o_mem.re && o_mem.addr == {STACK_PAGE, sp_r}
      && sp_r == $past(sp_r) + 8'h01)
    else $error("pull read not at incremented pointer");

  chk_iter_to_sp: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_DECODE && !int_entry_r && kind == K_ITER_TO_SP |=> sp_r == $past(ix_r) && $stable(psw_r))
    else $error("iterator to sp transfer wrong");

  chk_sp_to_iter: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_DECODE && !int_entry_r && kind == K_SP_TO_ITER |=> ix_r == $past(sp_r)
      && psw_r[PSW_N_BIT] == ix_r[7] && psw_r[PSW_Z_BIT] == (ix_r == 8'h00))
    else $error("sp to iterator transfer or flags wrong");

  chk_psw_push: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_PUSH && (int_entry_r || kind == K_PUSH_PSW) |-> o_mem.wdata == psw_r && $stable(ix_r))
    else $error("status push data wrong");

  chk_psw_pull: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_PULL_READ && kind == K_PULL_PSW |=> psw_r == $past(i_mem_rdata) && $stable(acc_r))
    else $error("status pull load wrong");

  chk_acc_pull: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_PULL_READ && kind == K_PULL_ACC |=> acc_r == $past(i_mem_rdata)
      && psw_r[PSW_N_BIT] == acc_r[7] && psw_r[PSW_Z_BIT] == (acc_r == 8'h00))
    else $error("accumulator pull or flags wrong");

  chk_addr_page: assert property (@(posedge i_clk) disable iff (i_reset)
    o_mem.we || o_mem.re |-> o_mem.addr[ADDR_W-1:SP_W] == STACK_PAGE)
    else $error("stack access outside the stack page");

  chk_unsup_set: assert property (@(posedge i_clk) disable iff (i_reset)
    state_r == ST_DECODE && !int_entry_r && kind == K_NONE |=> unsup_r)
    else $error("unknown opcode did not raise its flag");

endmodule

// ---- verif/stack_mem.sv ----
// behavioural stack page memory on the far side of the unit
`timescale 1ns/1ps
module stack_mem
  import stack_pkg::*;
(
  input  wire logic        i_clk,
  input  stack_pkg::mem_req_type i_mem,
  output logic [DATA_W-1:0] o_rdata
);
  import stack_pkg::*;
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] last_r;

  ////////////////////////////////////////////////////////////
  // known fill so a stray read is visible
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'hE0 ^ i[7:0];
    end
    last_r = 8'h00;
  end

  // write lands on the rising edge that ends the strobe cycle
  always @(posedge i_clk) begin
    if (i_mem.we === 1'b1) begin
      mem[i_mem.addr[7:0]] <= i_mem.wdata;
    end
    if (i_mem.re === 1'b1) begin
      last_r <= mem[i_mem.addr[7:0]];
    end
  end

  // async read; off-strobe shows inverted data, never a stale copy
  assign o_rdata = (i_mem.re === 1'b1) ? mem[i_mem.addr[7:0]] : ~last_r;
endmodule

// ---- verif/testbench.sv ----
// directed apb testbench for the stack pointer unit
`timescale 1ns/1ps
module testbench;
  import stack_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  mem_req_type mem;
  logic [7:0]  mrd;
  logic [31:0] rdv;
  logic        rerr;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t_cmd;
  logic [15:0] wa[$];
  logic [15:0] ra[$];
  logic [7:0]  wd[$];
  int          wc[$];
  int          rc[$];

  always #5 i_clk = ~i_clk;

  stack_unit DUT (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_mem(mem), .i_mem_rdata(mrd));
  stack_mem mem_model (.i_clk(i_clk), .i_mem(mem), .o_rdata(mrd));

  ////////////////////////////////////////////////////////////
  // cycle count, hang guard and stack bus monitor
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc >= 20000) begin
      err_count++;
      conclude();
    end
    if (mem.we === 1'b1) begin
      wa.push_back(mem.addr);
      wd.push_back(mem.wdata);
      wc.push_back(cyc);
    end
    if (mem.re === 1'b1) begin
      ra.push_back(mem.addr);
      rc.push_back(cyc);
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////
  // apb master: idle edge first so no signal is driven twice per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // no local limit: only the bench timeout may end this wait
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    t_cmd = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // issue one instruction and wait until the unit goes idle
  task automatic cmd(input logic [31:0] op);
    int t;
    wr(OFF_CMD, op);
    t = t_cmd;
    // poll until idle; a stuck unit is caught by the bench timeout
    do begin
      rd(OFF_STATUS);
    end while (rdv[STAT_BUSY_BIT] !== 1'b0);
    t_cmd = t;
  endtask

  task automatic reg_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    check(name, rdv, exp);
  endtask

  task automatic qclear();
    wa = {};
    wd = {};
    wc = {};
    ra = {};
    rc = {};
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    // reset values, sp read-only
    reg_chk("sp_rst", OFF_SP, 32'h0000_00FF);
    reg_chk("ix_rst", OFF_IX, 32'h0);
    check("map_err", rerr, 1'b0);
    wr(OFF_SP, 32'h0000_0012);
    reg_chk("sp_ro", OFF_SP, 32'h0000_00FF);
    $display("test reset done");
    // sp set through iterator, flags kept
    wr(OFF_PSW, 32'h0000_00C3);
    wr(OFF_IX, 32'h0000_0080);
    cmd(OPC_ITER_TO_SP);
    reg_chk("sp_load", OFF_SP, 32'h0000_0080);
    reg_chk("psw_keep", OFF_PSW, 32'h0000_00C3);
    // sp to iterator, negative then zero result
    wr(OFF_PSW, 32'h0000_0041);
    wr(OFF_IX, 32'h0000_0005);
    cmd(OPC_SP_TO_ITER);
    reg_chk("ix_copy", OFF_IX, 32'h0000_0080);
    reg_chk("psw_neg", OFF_PSW, 32'h0000_00C1);
    wr(OFF_IX, 32'h0);
    cmd(OPC_ITER_TO_SP);
    wr(OFF_IX, 32'h0000_0005);
    cmd(OPC_SP_TO_ITER);
    reg_chk("ix_zero", OFF_IX, 32'h0);
    reg_chk("psw_zero", OFF_PSW, 32'h0000_0043);
    $display("test transfers done");
    // push accumulator from sp 00: page address, third cycle, wrap
    wr(OFF_ACC, 32'h0000_005A);
    qclear();
    cmd(OPC_PUSH_ACC);
    check("pha_addr", wa[0], 32'h0000_0100);
    check("pha_data", wd[0], 32'h0000_005A);
    check("pha_cyc", wc[0], t_cmd + 2);
    check("pha_n", wa.size(), 1);
    reg_chk("sp_wrap", OFF_SP, 32'h0000_00FF);
    reg_chk("psw_pha", OFF_PSW, 32'h0000_0043);
    // push status word, then interrupt entry
    wr(OFF_PSW, 32'h0000_00A5);
    qclear();
    cmd(OPC_PUSH_PSW);
    check("php_addr", wa[0], 32'h0000_01FF);
    check("php_data", wd[0], 32'h0000_00A5);
    reg_chk("php_psw", OFF_PSW, 32'h0000_00A5);
    reg_chk("php_acc", OFF_ACC, 32'h0000_005A);
    reg_chk("php_sp", OFF_SP, 32'h0000_00FE);
    wr(OFF_PSW, 32'h0000_003C);
    qclear();
    cmd(32'h0000_0100);
    check("int_addr", wa[0], 32'h0000_01FE);
    check("int_data", wd[0], 32'h0000_003C);
    reg_chk("int_sp", OFF_SP, 32'h0000_00FD);
    $display("test pushes done");
    // pull accumulator: dummy read, then read after increment
    wr(OFF_PSW, 32'h0000_00C3);
    qclear();
    cmd(OPC_PULL_ACC);
    check("pla_dummy", ra[0], 32'h0000_01FD);
    check("pla_addr", ra[1], 32'h0000_01FE);
    check("pla_cyc", rc[1], t_cmd + 3);
    reg_chk("pla_acc", OFF_ACC, 32'h0000_003C);
    reg_chk("pla_psw", OFF_PSW, 32'h0000_0041);
    reg_chk("pla_sp", OFF_SP, 32'h0000_00FE);
    // pull status word takes the whole byte
    cmd(OPC_PULL_PSW);
    reg_chk("plp_psw", OFF_PSW, 32'h0000_00A5);
    reg_chk("plp_acc", OFF_ACC, 32'h0000_003C);
    reg_chk("plp_sp", OFF_SP, 32'h0000_00FF);
    $display("test pulls done");
    // stack users among all opcodes, then an unknown one
    for (int i = 1; i <= 10; i++) begin
      cmd(i);
      reg_chk("uses", OFF_STATUS, (i >= 3) ? 32'h4 : 32'h0);
    end
    cmd(32'h0000_00FF);
    reg_chk("unsup", OFF_STATUS, 32'h0000_0002);
    wr(OFF_STATUS, 32'h0000_0002);
    reg_chk("unsup_clr", OFF_STATUS, 32'h0);
    // unmapped address answers with an error
    rd(12'h018);
    check("unmap_err", rerr, 1'b1);
    check("unmap_data", rdv, 32'h0);
    wr(12'h018, 32'h1);
    check("unmap_werr", rerr, 1'b1);
    $display("test decode done");
    conclude();
  end
endmodule
